// ==== include/playback_pkg.sv ====
// Constants, register map and state encoding for the playback host port.
// Assumes a 250 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package playback_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_HW_CTRL = 8'h00;
    localparam logic [7:0] ADDR_HW_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SW_CTRL = 8'h08;
    localparam logic [7:0] ADDR_SW_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_TX_DATA = 8'h10;

    // ==========================================================
    // Hardware control and status bit positions
    localparam int HC_TX_READY_IE = 1;
    localparam int HC_BURST_MODE = 5;
    localparam int HC_TX_DMA_EN = 7;
    localparam int HC_DMA_DIR = 8;
    localparam int HC_MASTER_IE = 10;
    localparam int HS_TX_READY = 0;
    localparam int HS_STATUS_READY = 1;
    localparam int HS_CONTROL_READY = 2;
    localparam int HS_DATA_PHASE = 3;
    localparam int HS_DMA_ACK = 4;

    // ==========================================================
    // Reset values
    localparam logic [15:0] HW_CTRL_RESET = 16'h0000;
    localparam logic [15:0] SW_STATUS_RESET = 16'h0000;
    localparam logic [7:0] RATE_WORDS_RESET = 8'h10;

    // ==========================================================
    // Command words and fields
    localparam logic [15:0] CMD_IDLE = 16'h0000;
    localparam logic [15:0] CMD_STOP_PLAY = 16'h5220;
    localparam logic [15:0] CMD_POLL_SYNC = 16'h5202;
    localparam logic [15:0] CMD_BUF_MON = 16'h5212;
    localparam logic [15:0] CMD_SECOND_WORD = 16'h2000;
    localparam logic [11:0] CMD_RATE_HI = 12'h523;
    localparam logic [7:0] CMD_FIRST_HI = 8'h2c;
    localparam logic [7:0] CMD_THIRD_HI = 8'h20;
    localparam logic [7:0] BUF_MON_REPLY_HI = 8'h00;
    localparam logic [1:0] TFR_BUFFER_PORT = 2'b11;
    localparam logic [2:0] PLAYMODE_COMPRESSED = 3'b000;
    localparam logic [2:0] PLAYMODE_LINEAR16 = 3'b110;

    // ==========================================================
    // Frame and buffer sizes in 16-bit words
    localparam logic [7:0] LINEAR16_FRAME_WORDS = 8'hf0;
    localparam logic [7:0] BYTE_FRAME_WORDS = 8'h78;
    localparam logic [7:0] TXBUF_WORDS = 8'h10;
    localparam logic [8:0] QUEUE_WORDS = 9'h0f0;
    localparam logic [7:0] RATE0_WORDS = 8'h10;
    localparam logic [7:0] RATE1_WORDS = 8'h0c;
    localparam logic [7:0] RATE2_WORDS = 8'h0a;
    localparam logic [7:0] RATE3_WORDS = 8'h09;
    localparam logic [7:0] RATE4_WORDS = 8'h08;

    // ==========================================================
    // Timing
    localparam int FRAME_PERIOD_MS = 30;
    localparam int CLK_FREQ_HZ = 250_000_000;
    localparam int FRAME_CYCLES = FRAME_PERIOD_MS * (CLK_FREQ_HZ / 1000);
    localparam int FRAME_CNT_W = 23;
    localparam logic [1:0] SYNC_FRAMES = 2'h2;

    // ==========================================================
    // Bus answers and states
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_WAIT_C2 = 3'b011,
        ST_WAIT_C3 = 3'b010,
        ST_DATA = 3'b110,
        ST_STREAM = 3'b101
    } play_state_t;

endpackage : playback_pkg

// ==== rtl/playback_host_transfer_port.sv ====
// Playback side of the host port: command/echo path, transmit buffer, DMA request.
// Assumes an AXI4-Lite master on clk_sys and an external DMA controller on the pins.
// Notes on behaviour
// RULE1 - Linear playback consumes one 240-word frame every 30 ms period.
// RULE2 - With transmit DMA enabled, DMA request follows transmit-buffer-ready.
// RULE3 - DMA answers request with acknowledge, then burst-writes 16 words.
// RULE4 - After a full sub-frame ready drops and words move into the queue.
// RULE5 - Host disables requests, then sends idle or stop-playback to end playback.
// RULE6 - Idle or stop ends playback, clears ready, posts a status reply.
// RULE7 - After idle or stop nobody touches the transmit data port.
// RULE8 - Host waits for status-ready; reading the status register clears it.
// RULE9 - Host checks control-ready before a command sequence.
// RULE10 - Rate-select and poll-sync commands are each answered in the status register.
// RULE11 - First command word enters playback, waits one to two frames, echoes.
// RULE12 - Second command word 2000H is answered with 2000H.
// RULE13 - Third command word carries the requested word count in its low byte.
// RULE14 - Third word is answered with the granted count, possibly zero.
// RULE15 - Non-zero grant lowers the data flag until the last data word.
// RULE16 - Each data word written is echoed in the status register.
// RULE17 - After moving a sub-frame the buffer returns and ready rises, queue full or not.
// RULE18 - Queue and buffer both full keeps ready low until the next period frees space.
// RULE19 - The frame held in the buffer is not counted by buffer monitoring.
// RULE20 - Linear frames move as 15 sixteen-word sub-frames, offset by 16 words.
// RULE21 - 8-bit frames move as seven 16-word sub-frames plus one 8-word sub-frame.
// RULE22 - 8-bit host software re-checks ready at least every 8 words.
// RULE23 - Control writes 00A0H or 01A0H enable transmit DMA burst mode.
// RULE24 - Control write 0402H enables the transmit-ready interrupt.
// RULE25 - Transmit writes while ready is low are ignored; buffer holds 16 words.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps

module playback_host_transfer_port #(
    parameter int FRAME_CYCLES = playback_pkg::FRAME_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [playback_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [playback_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic tx_dma_ack_n,
    output logic tx_dma_request,
    output logic data_phase_flag_n,
    output logic tx_ready_irq
);
    import playback_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        play_state_t st;
        logic [15:0] hw_ctrl;
        logic [15:0] sw_status;
        logic [15:0] first_word;
        logic status_ready;
        logic tx_ready;
        logic [4:0] txb_cnt;
        logic [8:0] queue_words;
        logic [7:0] queue_frames;
        logic [7:0] frame_pos;
        logic [7:0] rate_words;
        logic [7:0] xfer_left;
        logic [2:0] playmode;
        logic [1:0] tfr;
        logic [1:0] sync_ticks;
        logic [FRAME_CNT_W-1:0] frame_cnt;
        logic ack_meta;
        logic ack_seen;
        logic flag_n;
        logic dma_req;
        logic irq;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } port_state_t;

    port_state_t s;
    port_state_t next_s;
    logic wr_go;
    logic rd_go;

    // ==========================================================
    // Decoding helpers
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        return (a == ADDR_HW_CTRL) || (a == ADDR_HW_STATUS) || (a == ADDR_SW_CTRL) ||
               (a == ADDR_SW_STATUS) || (a == ADDR_TX_DATA);
    endfunction : reg_hit

    function automatic logic [7:0] rate_to_words(input logic [3:0] r);
        case (r)
            4'h1: return RATE1_WORDS;
            4'h2: return RATE2_WORDS;
            4'h3: return RATE3_WORDS;
            4'h4: return RATE4_WORDS;
            default: return RATE0_WORDS;
        endcase
    endfunction : rate_to_words

    function automatic logic [7:0] frame_words(input logic [2:0] pm, input logic [7:0] rw);
        if (pm == PLAYMODE_COMPRESSED) begin
            return rw;
        end else if (pm == PLAYMODE_LINEAR16) begin
            return LINEAR16_FRAME_WORDS;
        end
        return BYTE_FRAME_WORDS;
    endfunction : frame_words

    // Handshakes on the bus
    assign wr_go = s.awready && awvalid && wvalid;
    assign rd_go = s.arready && arvalid;

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [7:0] fw;
        logic [7:0] sub;
        logic [8:0] cap;
        logic [8:0] space;
        logic [15:0] cmd;
        logic [15:0] hs;
        logic [7:0] grant;
        logic frame_tick;
        fw = frame_words(s.playmode, s.rate_words);
        sub = ((fw - s.frame_pos) > TXBUF_WORDS) ? TXBUF_WORDS : 8'(fw - s.frame_pos); // RULE20 RULE21
        cap = (s.playmode == PLAYMODE_COMPRESSED) ? QUEUE_WORDS : {1'b0, fw};
        space = cap - s.queue_words;
        cmd = wdata[15:0];
        hs = 16'h0000;
        grant = 8'h00;
        frame_tick = (s.frame_cnt == FRAME_CNT_W'(FRAME_CYCLES - 1));
        next_s = s;

        // Acknowledge pin synchroniser, active high inside
        next_s.ack_meta = ~tx_dma_ack_n;
        next_s.ack_seen = s.ack_meta;

        // Free-running frame period timer
        next_s.frame_cnt = frame_tick ? '0 : s.frame_cnt + 1'b1;

        // Playback drains one frame per period
        if (frame_tick && (s.st != ST_IDLE) && (s.st != ST_SYNC) && (s.queue_words >= {1'b0, fw})) begin
            next_s.queue_words = s.queue_words - {1'b0, fw}; // RULE1
            next_s.queue_frames = s.queue_frames - 8'h01;
        end

        // Full transmit buffer moves into the queue when space allows
        if ((s.st == ST_STREAM) && ({3'b000, s.txb_cnt} == sub)) begin
            if (space >= {1'b0, sub}) begin
                next_s.queue_words = next_s.queue_words + {1'b0, sub}; // RULE4
                next_s.txb_cnt = 5'h00;
                next_s.tx_ready = 1'b1; // RULE17
                if ((s.frame_pos + sub) == fw) begin
                    next_s.frame_pos = 8'h00;
                    next_s.queue_frames = next_s.queue_frames + 8'h01; // RULE19
                end else begin
                    next_s.frame_pos = s.frame_pos + sub; // RULE20 RULE21
                end
            end else begin
                next_s.tx_ready = 1'b0; // RULE18
            end
        end

        // Read channel
        if (rd_go) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = reg_hit(araddr) ? AXI_OKAY : AXI_SLVERR;
            hs[HS_TX_READY] = s.tx_ready;
            hs[HS_STATUS_READY] = s.status_ready;
            hs[HS_CONTROL_READY] = (s.st != ST_SYNC) && !s.status_ready;
            hs[HS_DATA_PHASE] = ~s.flag_n;
            hs[HS_DMA_ACK] = s.ack_seen;
            case (araddr)
                ADDR_HW_CTRL: next_s.rdata = {16'h0000, s.hw_ctrl};
                ADDR_HW_STATUS: next_s.rdata = {16'h0000, hs};
                ADDR_SW_STATUS: next_s.rdata = {16'h0000, s.sw_status};
                default: next_s.rdata = 32'h0000_0000;
            endcase
            if (araddr == ADDR_SW_STATUS) begin
                next_s.status_ready = 1'b0; // RULE8
            end
        end else if (arvalid && !s.arready && !s.rvalid) begin
            next_s.arready = 1'b1;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end

        // Synchronisation delay after the first command word
        if ((s.st == ST_SYNC) && frame_tick) begin
            next_s.sync_ticks = s.sync_ticks + 2'h1;
            if (s.sync_ticks == (SYNC_FRAMES - 2'h1)) begin
                next_s.sw_status = s.first_word; // RULE11
                next_s.status_ready = 1'b1;
                next_s.st = (s.tfr == TFR_BUFFER_PORT) ? ST_STREAM : ST_WAIT_C2;
                next_s.tx_ready = (s.tfr == TFR_BUFFER_PORT);
            end
        end

        // Write channel
        if (wr_go) begin
            next_s.awready = 1'b0;
            next_s.wready = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = reg_hit(awaddr) ? AXI_OKAY : AXI_SLVERR;
            case (awaddr)
                ADDR_HW_CTRL: begin
                    if (wstrb[0]) begin
                        next_s.hw_ctrl[7:0] = wdata[7:0]; // RULE23 RULE24
                    end
                    if (wstrb[1]) begin
                        next_s.hw_ctrl[15:8] = wdata[15:8];
                    end
                end
                ADDR_TX_DATA: begin
                    if ((s.st == ST_STREAM) && s.tx_ready && ({3'b000, s.txb_cnt} < sub)) begin
                        next_s.txb_cnt = s.txb_cnt + 5'h01; // RULE25
                        if ({3'b000, s.txb_cnt + 5'h01} == sub) begin
                            next_s.tx_ready = 1'b0; // RULE4
                        end
                    end
                end
                ADDR_SW_CTRL: begin
                    if (wstrb[1:0] == 2'b11) begin
                        next_s.status_ready = 1'b1;
                        next_s.sw_status = cmd; // RULE10 RULE16
                        if (s.st == ST_DATA) begin
                            next_s.queue_words = next_s.queue_words + 9'h001;
                            next_s.xfer_left = s.xfer_left - 8'h01;
                            if (s.xfer_left == 8'h01) begin
                                next_s.flag_n = 1'b1; // RULE15
                                next_s.st = ST_WAIT_C2;
                                next_s.queue_frames = next_s.queue_frames + 8'h01;
                            end
                        end else if ((cmd == CMD_IDLE) || (cmd == CMD_STOP_PLAY)) begin
                            next_s.st = ST_IDLE; // RULE6
                            next_s.tx_ready = 1'b0;
                            next_s.txb_cnt = 5'h00;
                            next_s.queue_words = 9'h000;
                            next_s.queue_frames = 8'h00;
                            next_s.flag_n = 1'b1;
                        end else if ((cmd[15:8] == CMD_FIRST_HI) && (s.st == ST_IDLE)) begin
                            next_s.status_ready = s.status_ready && !(rd_go && (araddr == ADDR_SW_STATUS));
                            next_s.sw_status = s.sw_status;
                            next_s.st = ST_SYNC; // RULE11
                            next_s.first_word = cmd;
                            next_s.playmode = cmd[6:4];
                            next_s.tfr = cmd[1:0];
                            next_s.sync_ticks = 2'h0;
                            next_s.frame_pos = 8'h00;
                            next_s.queue_words = 9'h000;
                            next_s.queue_frames = 8'h00;
                        end else if ((cmd == CMD_SECOND_WORD) && (s.st == ST_WAIT_C2)) begin
                            next_s.st = ST_WAIT_C3; // RULE12
                        end else if ((cmd[15:8] == CMD_THIRD_HI) && (s.st == ST_WAIT_C3)) begin
                            if ((cmd[7:0] <= fw) && ({1'b0, cmd[7:0]} <= space)) begin
                                grant = cmd[7:0];
                            end
                            next_s.sw_status = {CMD_THIRD_HI, grant}; // RULE14
                            next_s.xfer_left = grant;
                            next_s.st = (grant != 8'h00) ? ST_DATA : ST_WAIT_C2;
                            next_s.flag_n = (grant == 8'h00); // RULE15
                        end else if (cmd[15:4] == CMD_RATE_HI) begin
                            next_s.rate_words = rate_to_words(cmd[3:0]); // RULE10
                        end else if (cmd == CMD_BUF_MON) begin
                            next_s.sw_status = {BUF_MON_REPLY_HI, s.queue_frames}; // RULE19
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (awvalid && wvalid && !s.awready && !s.bvalid) begin
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end

        // Registered pin and interrupt outputs
        next_s.dma_req = next_s.hw_ctrl[HC_TX_DMA_EN] && next_s.tx_ready; // RULE2
        next_s.irq = next_s.hw_ctrl[HC_MASTER_IE] && next_s.hw_ctrl[HC_TX_READY_IE] && next_s.tx_ready; // RULE24
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.hw_ctrl <= HW_CTRL_RESET;
            s.sw_status <= SW_STATUS_RESET;
            s.rate_words <= RATE_WORDS_RESET;
            s.flag_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;
    assign tx_dma_request = s.dma_req;
    assign data_phase_flag_n = s.flag_n;
    assign tx_ready_irq = s.irq;

    // ==========================================================
    // Assertions
    property p_dma_follows_ready;
        @(posedge clk_sys) disable iff (rst)
        tx_dma_request == (s.hw_ctrl[HC_TX_DMA_EN] && s.tx_ready);
    endproperty
    a_dma_follows_ready: assert property (p_dma_follows_ready) else $error("dma request not tied to ready"); // RULE2

    property p_full_drops_ready;
        @(posedge clk_sys) disable iff (rst)
        (wr_go && (awaddr == ADDR_TX_DATA) && (s.st == ST_STREAM) && s.tx_ready && (s.txb_cnt == 5'h0f)
            && (s.playmode == PLAYMODE_LINEAR16)) |=> !s.tx_ready ##1 (s.txb_cnt == 5'h10 || s.tx_ready);
    endproperty
    a_full_drops_ready: assert property (p_full_drops_ready) else $error("ready stayed high on full buffer"); // RULE4

    property p_stop_ends;
        @(posedge clk_sys) disable iff (rst)
        (wr_go && (awaddr == ADDR_SW_CTRL) && (wstrb[1:0] == 2'b11) && (s.st != ST_DATA)
            && ((wdata[15:0] == CMD_IDLE) || (wdata[15:0] == CMD_STOP_PLAY)))
            |=> (s.st == ST_IDLE) && !s.tx_ready && s.status_ready ##1 !tx_dma_request;
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop did not end playback"); // RULE6

    property p_status_read_clears;
        @(posedge clk_sys) disable iff (rst)
        (rd_go && (araddr == ADDR_SW_STATUS) && !wr_go && !((s.st == ST_SYNC) && (s.frame_cnt != 0)))
            |=> !s.status_ready;
    endproperty
    a_status_read_clears: assert property (p_status_read_clears) else $error("status ready not cleared"); // RULE8

    property p_first_word_sync;
        @(posedge clk_sys) disable iff (rst)
        (wr_go && (awaddr == ADDR_SW_CTRL) && (wstrb[1:0] == 2'b11) && (s.st == ST_IDLE)
            && (wdata[15:8] == CMD_FIRST_HI)) |=> (s.st == ST_SYNC) [*2];
    endproperty
    a_first_word_sync: assert property (p_first_word_sync) else $error("first word did not start sync"); // RULE11

    property p_grant_flag;
        @(posedge clk_sys) disable iff (rst)
        (s.st == ST_DATA) |-> !data_phase_flag_n && (s.xfer_left != 8'h00);
    endproperty
    a_grant_flag: assert property (p_grant_flag) else $error("data flag wrong in data phase"); // RULE15

    property p_data_echo;
        @(posedge clk_sys) disable iff (rst)
        (wr_go && (awaddr == ADDR_SW_CTRL) && (wstrb[1:0] == 2'b11) && (s.st == ST_DATA))
            |=> (s.sw_status == $past(wdata[15:0])) && s.status_ready;
    endproperty
    a_data_echo: assert property (p_data_echo) else $error("data word not echoed"); // RULE16

    property p_ignored_write;
        @(posedge clk_sys) disable iff (rst)
        (wr_go && (awaddr == ADDR_TX_DATA) && !s.tx_ready && (s.st == ST_STREAM)) |=> (s.txb_cnt <= $past(s.txb_cnt));
    endproperty
    a_ignored_write: assert property (p_ignored_write) else $error("write taken while not ready"); // RULE25

    property p_buffer_cap;
        @(posedge clk_sys) disable iff (rst)
        (s.txb_cnt <= 5'h10) && (s.queue_words <= QUEUE_WORDS);
    endproperty
    a_buffer_cap: assert property (p_buffer_cap) else $error("buffer count out of range"); // RULE25 RULE18

    c_stream_fill: cover property (@(posedge clk_sys) disable iff (rst) (s.st == ST_STREAM) && (s.txb_cnt == 5'h10));
    c_data_phase: cover property (@(posedge clk_sys) disable iff (rst) (s.st == ST_DATA) ##1 (s.st == ST_WAIT_C2));
    c_dma_request: cover property (@(posedge clk_sys) disable iff (rst) $rose(tx_dma_request));
    c_short_sub: cover property (@(posedge clk_sys) disable iff (rst) (s.frame_pos == 8'h70) && (s.txb_cnt == 5'h08));

endmodule : playback_host_transfer_port

// ==== test/host_dma_model.sv ====
// Host and DMA controller model: AXI4-Lite master and DMA acknowledge pin.
// Assumes clk_sys from the bench; the bench calls its tasks.
`timescale 1ns/10ps
module host_dma_model import playback_pkg::*; (
    input wire logic clk_sys,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready,
    output logic tx_dma_ack_n,
    input wire logic tx_dma_request
);
    // ==========================================
    // Idle bus
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
        tx_dma_ack_n = 1'b1;
    end
    // One write, address and data together
    task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= {16'h0000, v};
        {awvalid, wvalid, bready} <= 3'b111;
        do @(posedge clk_sys); while (awready !== 1'b1);
        {awvalid, wvalid} <= 2'b00;
        wdata <= ~wdata;
        while (bvalid !== 1'b1) @(posedge clk_sys);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    // One read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_sys);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    // Acknowledge, then burst 16 words into the data port
    task automatic dma_burst();
        logic [1:0] r;
        @(posedge clk_sys);
        tx_dma_ack_n <= 1'b0;
        for (int i = 0; i < 16; i++) wr(ADDR_TX_DATA, 16'($urandom), r);
        tx_dma_ack_n <= 1'b1;
    endtask : dma_burst
endmodule : host_dma_model

// ==== test/tb.sv ====
// Self-checking bench: command/echo path, linear DMA stream, then 8-bit stream.
// Assumes host_dma_model as far side; frame period shortened to 2000 cycles.
`timescale 1ns/10ps
module tb;
    import playback_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic tx_dma_ack_n, tx_dma_request, data_phase_flag_n, tx_ready_irq;
    logic [15:0] w;
    int bad_count = 0, compares = 0, rnd, bursts;
    time t;
    playback_host_transfer_port #(.FRAME_CYCLES(2000)) DUT (.*);
    host_dma_model u_host (.*);
    // ==========================================
    // Clock
    always #2 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic cmd(input logic [15:0] c, input logic [15:0] want);
        u_host.wr(ADDR_SW_CTRL, c, r);
        for (int i = 0; i < 1500 && d[HS_STATUS_READY] !== 1'b1; i++) u_host.rd(ADDR_HW_STATUS, d, r);
        u_host.rd(ADDR_SW_STATUS, d, r);
        check(d[15:0], want);
        d = '0;
    endtask : cmd
    task automatic wait_req(input int lim);
        for (int i = 0; i < lim && tx_dma_request !== 1'b1; i++) @(posedge clk_sys);
    endtask : wait_req
    // Watchdog
    initial begin
        #200000;
        bad_count++;
        close_out();
    end
    // ==========================================
    // Main sequence
    initial begin
        rnd = $urandom(32'h5f01);
        d = '0;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        u_host.rd(ADDR_HW_STATUS, d, r);
        check(d[4:0], 5'h04);
        u_host.rd(8'h40, d, r);
        check(r, AXI_SLVERR);
        cmd(16'h5230, 16'h5230);
        cmd(CMD_POLL_SYNC, CMD_POLL_SYNC);
        u_host.rd(ADDR_HW_STATUS, d, r);
        check(d[HS_STATUS_READY], 1'b0);
        t = $time;
        cmd(16'h2c00, 16'h2c00);
        check(($time - t) / 4 inside {[2000:4100]}, 1'b1);
        repeat (2) begin
            cmd(CMD_SECOND_WORD, CMD_SECOND_WORD);
            cmd(16'h2010, 16'h2010);
            check(data_phase_flag_n, 1'b0);
            repeat (16) begin
                w = 16'($urandom);
                cmd(w, w);
            end
            check(data_phase_flag_n, 1'b1);
        end
        cmd(CMD_STOP_PLAY, CMD_STOP_PLAY);
        // Linear stream: 256 words fit in the first period
        cmd(16'h2c63, 16'h2c63);
        u_host.wr(ADDR_HW_CTRL, 16'h01a0, r);
        bursts = 0;
        repeat (16) begin
            wait_req(40);
            check(tx_dma_request, 1'b1);
            check(tx_ready_irq, 1'b0);
            u_host.dma_burst();
            bursts += 16;
        end
        wait_req(100);
        check(tx_dma_request, 1'b0);
        u_host.wr(ADDR_TX_DATA, 16'h1234, r);
        check(r, AXI_OKAY);
        cmd(CMD_BUF_MON, 16'h0001);
        u_host.wr(ADDR_HW_CTRL, 16'h05a2, r);
        wait_req(2500);
        check(tx_dma_request, 1'b1);
        check(tx_ready_irq, 1'b1);
        // Stop; data port left alone afterwards
        u_host.wr(ADDR_HW_CTRL, HW_CTRL_RESET, r);
        cmd(CMD_IDLE, CMD_IDLE);
        u_host.rd(ADDR_HW_STATUS, d, r);
        check(d[HS_TX_READY], 1'b0);
        // 8-bit stream: seven 16-word sub-frames, one of 8, then a held 16
        cmd(16'h2c13, 16'h2c13);
        u_host.wr(ADDR_HW_CTRL, 16'h00a0, r);
        for (int n = 0; n < 9; n++) begin
            wait_req(40);
            check(tx_dma_request, 1'b1);
            if (n == 7) begin
                repeat (8) u_host.wr(ADDR_TX_DATA, 16'($urandom), r);
            end else begin
                u_host.dma_burst();
            end
        end
        wait_req(100);
        check(tx_dma_request, 1'b0);
        close_out();
    end
endmodule : tb
